/* File: include/rtcct_pkg.sv */
// Package for the real-time clock/calendar timer block.
// Assumes a single 50 MHz system clock and byte-addressed 16-bit registers.
package rtcct_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, word aligned)
    // ------------------------------------------------------------
    localparam logic [6:0]  MS_OFFSET     = 7'h78;   // minutes_seconds_time
    localparam logic [6:0]  DH_OFFSET     = 7'h7a;   // day_hour_time
    localparam logic [6:0]  YM_OFFSET     = 7'h7c;   // year_month_time

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SEC_LSB   = 0;    // Seconds [5:0]
    localparam int MIN_LSB   = 8;    // Minutes [13:8]
    localparam int HOUR_LSB  = 0;    // Hours [5:0]
    localparam int DAY_LSB   = 8;    // Day [12:8]
    localparam int MONTH_LSB = 0;    // Month [3:0]
    localparam int YEAR_LSB  = 8;    // Year [14:8]
    localparam int MODE_BIT  = 0;    // Calendar select in setup register

    // ------------------------------------------------------------
    // Field limits
    // ------------------------------------------------------------
    localparam logic [5:0] SEC_MAX   = 6'h3b;   // 59
    localparam logic [5:0] MIN_MAX   = 6'h3b;   // 59
    localparam logic [5:0] HOUR_MAX  = 6'h17;   // 23
    localparam logic [4:0] DAY_MAX   = 5'h1f;   // 31
    localparam logic [3:0] MONTH_MAX = 4'hc;    // 12
    localparam logic [6:0] YEAR_MAX  = 7'h63;   // 99, offset from 2000
    localparam logic [4:0] DAY_MIN   = 5'h01;
    localparam logic [3:0] MONTH_MIN = 4'h1;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] TIME_RESET   = 16'h0000;  // Elapsed timer start
    localparam int          CLK_HZ       = 50_000_000;
    localparam int          TICK_PERIOD_S = 1;        // Seconds per tick
    localparam int          TICK_CYCLES  = CLK_HZ * TICK_PERIOD_S;

    // Write strobe kinds for the time store
    typedef enum logic [2:0] {
        RTCCT_WR_MS = 3'b001,
        RTCCT_WR_DH = 3'b010,
        RTCCT_WR_YM = 3'b100
    } rtcct_wr_t;

endpackage : rtcct_pkg

/* File: include/rtcct_time_if.sv */
// Interface carrying the running time between the counter and register file.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface rtcct_time_if;
    logic [5:0] sec;        // Seconds 0..59
    logic [5:0] min;        // Minutes 0..59
    logic [5:0] hour;       // Hours 0..23
    logic [4:0] day;        // Day 1..31, 0..31 in elapsed mode
    logic [3:0] month;      // Month 1..12, 0..12 in elapsed mode
    logic [6:0] year;       // Year 0..99
    logic       load;       // Apply staged values
    logic [5:0] ld_sec;     // Staged values
    logic [5:0] ld_min;
    logic [5:0] ld_hour;
    logic [4:0] ld_day;
    logic [3:0] ld_month;
    logic [6:0] ld_year;
    logic       calendar;   // Calendar mode selected

    modport counter (output sec, min, hour, day, month, year,
                     input load, ld_sec, ld_min, ld_hour, ld_day, ld_month, ld_year,
                     calendar);
    modport regs    (input sec, min, hour, day, month, year,
                     output load, ld_sec, ld_min, ld_hour, ld_day, ld_month, ld_year,
                     calendar);
endinterface : rtcct_time_if

/* File: logic/rtcct_counter.sv */
// Time counter for the real-time clock; lives in the clock's own supply domain.
// Assumes sys_clk keeps running while the clock domain supply is present.
`timescale 1ns/1ps
module rtcct_counter #(
    parameter int TICK_CYCLES = rtcct_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic     sys_clk,
    input  wire logic     srst,
    // Time link to register file
    rtcct_time_if.counter tm,
    // Seconds tick, one cycle
    output logic          tick
);

    // ------------------------------------------------------------
    // Tick prescaler
    // ------------------------------------------------------------
    logic [31:0] pre_q;     // Cycles within the current second
    logic        pend_q;    // Staged load waiting for the tick

    // Free-running second divider
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pre_q <= 32'h0000_0000;
        end else if (pre_q == 32'(TICK_CYCLES - 1)) begin
            pre_q <= 32'h0000_0000;
        end else begin
            pre_q <= pre_q + 32'h0000_0001;
        end
    end

    assign tick = (pre_q == 32'(TICK_CYCLES - 1));

    // Load request stays pending until a tick takes it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pend_q <= 1'b0;
        end else if (tm.load) begin
            // Set wins over the tick that would clear it
            pend_q <= 1'b1;
        end else if (tick) begin
            pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Time fields
    // ------------------------------------------------------------
    logic c_s, c_m, c_h, c_d, c_mo;

    assign c_s  = tm.sec   == rtcct_pkg::SEC_MAX;
    assign c_m  = c_s  && tm.min  == rtcct_pkg::MIN_MAX;
    assign c_h  = c_m  && tm.hour == rtcct_pkg::HOUR_MAX;
    assign c_d  = c_h  && tm.day  == rtcct_pkg::DAY_MAX;
    assign c_mo = c_d  && tm.month == rtcct_pkg::MONTH_MAX;

    // Counting; elapsed mode starts from zero, calendar wraps day and month to 1
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tm.sec   <= 6'h00;
            tm.min   <= 6'h00;
            tm.hour  <= 6'h00;
            tm.day   <= 5'h00;
            tm.month <= 4'h0;
            tm.year  <= 7'h00;
        end else if (tick && pend_q) begin
            tm.sec   <= tm.ld_sec;
            tm.min   <= tm.ld_min;
            tm.hour  <= tm.ld_hour;
            tm.day   <= tm.ld_day;
            tm.month <= tm.ld_month;
            tm.year  <= tm.ld_year;
        end else if (tick) begin
            tm.sec  <= c_s ? 6'h00 : tm.sec + 6'h01;
            if (c_s) tm.min  <= c_m ? 6'h00 : tm.min + 6'h01;
            if (c_m) tm.hour <= c_h ? 6'h00 : tm.hour + 6'h01;
            if (c_h) tm.day  <= c_d ? (tm.calendar ? rtcct_pkg::DAY_MIN : 5'h00)
                                    : tm.day + 5'h01;
            if (c_d) tm.month <= c_mo ? (tm.calendar ? rtcct_pkg::MONTH_MIN : 4'h0)
                                      : tm.month + 4'h1;
            if (c_mo) tm.year <= (tm.year == rtcct_pkg::YEAR_MAX) ? 7'h00
                                                                   : tm.year + 7'h01;
        end
    end

endmodule : rtcct_counter

/* File: logic/rtcct_top.sv */
// Real-time clock/calendar register block behind the SPI register port.
// Assumes the SPI engine delivers decoded 16-bit word accesses on sys_clk.
`timescale 1ns/1ps
// Behaviour
// - Setup bit 0 selects calendar mode
// - Elapsed mode starts at zero, counts up
// - Writes stay pending until year byte
// - Committed values appear at next tick
// - Flash backup command stores settings
// - Counter sits in separate power domain
// - Access only after main startup completes
// - Minutes/seconds fields, unused bits zero
// - Day/hours fields, unused bits zero
// - Year/month fields, unused bits zero
module rtcct_top #(
    parameter int TICK_CYCLES = rtcct_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Register port from SPI engine
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [1:0]  reg_be,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    output logic             reg_ack,
    // Setup bit 0 and flash backup command from config block
    input  wire logic        setup_calendar,
    input  wire logic        flash_backup_cmd,
    output logic             flash_store_req,
    // Main domain power and startup state (asynchronous pin)
    input  wire logic        main_ready,
    // Seconds tick
    output logic             sec_tick
);

    // ------------------------------------------------------------
    // Startup qualification
    // ------------------------------------------------------------
    logic rdy_s1_q;        // First synchroniser stage
    logic rdy_s2_q;        // Usable ready level

    // Two-stage sync of the startup-complete level
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
        end else begin
            rdy_s1_q <= main_ready;
            rdy_s2_q <= rdy_s1_q;
        end
    end

    logic wr_ok, rd_ok;
    assign wr_ok = reg_wr && rdy_s2_q;
    assign rd_ok = reg_rd && rdy_s2_q;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
        hit = (a[6:1] == off[6:1]);
    endfunction : hit

    logic hit_ms, hit_dh, hit_ym;
    assign hit_ms = hit(reg_addr, rtcct_pkg::MS_OFFSET);
    assign hit_dh = hit(reg_addr, rtcct_pkg::DH_OFFSET);
    assign hit_ym = hit(reg_addr, rtcct_pkg::YM_OFFSET);

    // ------------------------------------------------------------
    // Counter and time link
    // ------------------------------------------------------------
    rtcct_time_if tm ();

    rtcct_counter #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_counter (
        .sys_clk (sys_clk),
        .srst    (srst),
        .tm      (tm),
        .tick    (sec_tick)
    );

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    logic cal_q;    // Registered calendar mode

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cal_q <= 1'b0;
        end else begin
            cal_q <= setup_calendar;
        end
    end
    assign tm.calendar = cal_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flash_store_req <= 1'b0;
        end else begin
            flash_store_req <= flash_backup_cmd;
        end
    end

    // ------------------------------------------------------------
    // Staging registers
    // ------------------------------------------------------------
    logic [5:0] st_sec_q, st_min_q, st_hour_q;
    logic [4:0] st_day_q;
    logic [3:0] st_month_q;
    logic [6:0] st_year_q;
    logic       load_q;     // Commit pulse to the counter

    // hold writes pending; drop unused bits
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_sec_q   <= 6'h00;
            st_min_q   <= 6'h00;
            st_hour_q  <= 6'h00;
            st_day_q   <= 5'h00;
            st_month_q <= 4'h0;
            st_year_q  <= 7'h00;
        end else if (wr_ok) begin
            if (hit_ms && reg_be[0]) st_sec_q <= reg_wdata[rtcct_pkg::SEC_LSB +: 6];
            if (hit_ms && reg_be[1]) st_min_q <= reg_wdata[rtcct_pkg::MIN_LSB +: 6];
            if (hit_dh && reg_be[0]) st_hour_q <= reg_wdata[rtcct_pkg::HOUR_LSB +: 6];
            if (hit_dh && reg_be[1]) st_day_q  <= reg_wdata[rtcct_pkg::DAY_LSB +: 5];
            if (hit_ym && reg_be[0]) st_month_q <= reg_wdata[rtcct_pkg::MONTH_LSB +: 4];
            if (hit_ym && reg_be[1]) st_year_q  <= reg_wdata[rtcct_pkg::YEAR_LSB +: 7];
        end
    end

    // year byte commits; relies on host order
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            load_q <= 1'b0;
        end else begin
            load_q <= wr_ok && hit_ym && reg_be[1];
        end
    end

    assign tm.load     = load_q;
    assign tm.ld_sec   = st_sec_q;
    assign tm.ld_min   = st_min_q;
    assign tm.ld_hour  = st_hour_q;
    assign tm.ld_day   = st_day_q;
    assign tm.ld_month = st_month_q;
    assign tm.ld_year  = st_year_q;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unused bits read as zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= rtcct_pkg::TIME_RESET;
        end else if (rd_ok) begin
            if (hit_ms) begin
                reg_rdata <= {2'b00, tm.min, 2'b00, tm.sec};
            end else if (hit_dh) begin
                reg_rdata <= {3'b000, tm.day, 2'b00, tm.hour};
            end else if (hit_ym) begin
                reg_rdata <= {1'b0, tm.year, 4'h0, tm.month};
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    // Acknowledge accepted accesses one cycle later
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= wr_ok || rd_ok;
        end
    end

endmodule : rtcct_top

/* File: sim/rtcct_host.sv */
// Host model: register accesses and setup words toward the clock block.
// Assumes the block's one-cycle strobes and registered acknowledge.
`timescale 1ns/1ps
module rtcct_host (
    // Clock
    input  wire logic        sys_clk,
    // Register port
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [6:0]       reg_addr,
    output logic [1:0]       reg_be,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_ack,
    // Setup level and backup pulse
    output logic             setup_calendar,
    output logic             flash_backup_cmd
);
    // Idle values at time zero
    initial begin
        {reg_wr, reg_rd, setup_calendar, flash_backup_cmd} = 4'h0;
        {reg_addr, reg_be, reg_wdata} = 25'h0000000;
    end

    // One access; address and data are scrambled once the strobe drops
    task automatic acc(input logic w, input logic [6:0] a, input logic [1:0] be,
                       input logic [15:0] d, output logic [15:0] q, output logic ok);
        ok = 1'b0;
        q = 16'h0000;
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_be <= be;
        reg_wdata <= d;
        @(posedge sys_clk);
        {reg_wr, reg_rd} <= 2'b00;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        // Refused accesses never answer, so the wait is capped
        for (int i = 0; i < 3 && !ok; i++) begin
            @(posedge sys_clk);
            if (reg_ack === 1'b1) begin
                ok = 1'b1;
                q = reg_rdata;
            end
        end
    endtask : acc

    task automatic word(input logic [15:0] w);
        @(posedge sys_clk);
        if (w[14:8] == 7'h0a) setup_calendar <= w[0];
        // Command byte 0x04 of the backup word carries the store request
        flash_backup_cmd <= (w[14:8] == 7'h02) && w[2];
        @(posedge sys_clk);
        flash_backup_cmd <= 1'b0;
    endtask : word
endmodule : rtcct_host

/* File: sim/rtcct_asserts.sv */
// Checker for the clock block, bound to the top module's ports.
// Assumes main_ready passes the same two-flop synchroniser as in the design.
`timescale 1ns/1ps
module rtcct_asserts #(
    parameter int TICK_CYCLES = rtcct_pkg::TICK_CYCLES
) (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [6:0]  reg_addr,
    input wire logic [1:0]  reg_be,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        setup_calendar,
    input wire logic        flash_backup_cmd,
    input wire logic        flash_store_req,
    input wire logic        main_ready,
    input wire logic        sec_tick
);
    logic        r1_q, r2_q, seen_q; // Ready sync copy, first tick seen
    logic [31:0] cnt_q;              // Cycles since the last tick
    wire logic   taken = (reg_wr || reg_rd) && r2_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Mirror of the ready synchroniser
    always_ff @(posedge sys_clk) begin
        r1_q <= !srst && main_ready;
        r2_q <= !srst && r1_q;
    end
    // Tick spacing counter
    always_ff @(posedge sys_clk) begin
        cnt_q <= (srst || sec_tick) ? 32'h00000000 : cnt_q + 32'h00000001;
    end
    always_ff @(posedge sys_clk) begin
        seen_q <= srst ? 1'b0 : (seen_q || sec_tick);
    end

    ack_after_a : assert property (taken |=> reg_ack)
        else $error("access taken without acknowledge");
    ack_cause_a : assert property (reg_ack |-> $past(taken))
        else $error("acknowledge without a taken access");
    store_req_a : assert property (flash_store_req == $past(flash_backup_cmd))
        else $error("flash store request not one cycle after command");
    tick_period_a : assert property (sec_tick && seen_q |-> cnt_q == TICK_CYCLES - 1)
        else $error("seconds tick spacing wrong");
    tick_late_a : assert property (seen_q |-> cnt_q < TICK_CYCLES)
        else $error("seconds tick missing");
    tick_pulse_a : assert property (sec_tick |=> !sec_tick)
        else $error("seconds tick longer than one cycle");
    reset_clear_a : assert property ($fell(srst) |-> !reg_ack && reg_rdata == 16'h0000)
        else $error("read side not cleared by reset");
    ms_unused_a : assert property (reg_ack && $past(reg_rd && reg_addr[6:1] == 6'h3c)
        |-> (reg_rdata & 16'hc0c0) == 16'h0000) else $error("minutes/seconds spare bits set");
    dh_unused_a : assert property (reg_ack && $past(reg_rd && reg_addr[6:1] == 6'h3d)
        |-> (reg_rdata & 16'he0c0) == 16'h0000) else $error("day/hours spare bits set");
    ym_unused_a : assert property (reg_ack && $past(reg_rd && reg_addr[6:1] == 6'h3e)
        |-> (reg_rdata & 16'h80f0) == 16'h0000) else $error("year/month spare bits set");

    cover property (sec_tick && seen_q);
    cover property (flash_store_req);
    cover property (reg_ack && $past(reg_wr));
endmodule : rtcct_asserts

bind rtcct_top rtcct_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.sys_clk(sys_clk),
    .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .setup_calendar(setup_calendar), .flash_backup_cmd(flash_backup_cmd),
    .flash_store_req(flash_store_req), .main_ready(main_ready), .sec_tick(sec_tick));

/* File: sim/tb.sv */
// Self-checking bench for the clock block with a short tick period.
// Assumes the host model and checker from this folder.
`timescale 1ns/1ps
module tb;
    localparam int TICKS = 40; // Short tick keeps the run brief
    logic        sys_clk, srst, main_ready, reg_wr, reg_rd, reg_ack, ok, pend_q;
    logic        setup_calendar, flash_backup_cmd, flash_store_req, sec_tick;
    logic [6:0]  reg_addr;
    logic [1:0]  reg_be;
    logic [15:0] reg_wdata, reg_rdata, q;
    logic [33:0] t_q, stg_q;   // {year, month, day, hour, min, sec}
    int          n_fail, num_checks, seed, n_store;

    rtcct_top #(.TICK_CYCLES(TICKS)) dut_u (.sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .setup_calendar(setup_calendar),
        .flash_backup_cmd(flash_backup_cmd), .flash_store_req(flash_store_req),
        .main_ready(main_ready), .sec_tick(sec_tick));
    rtcct_host host_u (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .setup_calendar(setup_calendar), .flash_backup_cmd(flash_backup_cmd));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [33:0] adv(input logic [33:0] t, input logic cal);
        logic [6:0] y;
        logic [3:0] mo;
        logic [4:0] d;
        logic [5:0] h, mi, s;
        {y, mo, d, h, mi, s} = t;
        s = s + 6'h01;
        if (s > 6'h3b) {s, mi} = {6'h00, mi + 6'h01};
        if (mi > 6'h3b) {mi, h} = {6'h00, h + 6'h01};
        if (h > 6'h17) {h, d} = {6'h00, d + 5'h01};
        if (h == 6'h00 && mi == 6'h00 && s == 6'h00 && d == 5'h00) begin
            d = {4'h0, cal};
            mo = mo + 4'h1;
        end
        if (mo > 4'hc) {mo, y} = {{3'h0, cal}, y + 7'h01};
        if (y > 7'h63) y = 7'h00;
        adv = {y, mo, d, h, mi, s};
    endfunction : adv

    // Expected register image; spare bits always zero
    function automatic logic [15:0] img(input logic [6:0] a, input logic [33:0] t);
        case ({a[6:1], 1'b0})
            7'h78: img = {2'h0, t[11:6], 2'h0, t[5:0]};
            7'h7a: img = {3'h0, t[22:18], 2'h0, t[17:12]};
            7'h7c: img = {1'h0, t[33:27], 4'h0, t[26:23]};
            default: img = 16'h0000;
        endcase
    endfunction : img

    // Random calendar time inside every field's range
    function automatic logic [33:0] rnd();
        rnd[33:27] = 7'($unsigned($random(seed)) % 100);
        rnd[26:23] = 4'($unsigned($random(seed)) % 12 + 1);
        rnd[22:18] = 5'($unsigned($random(seed)) % 31 + 1);
        rnd[17:12] = 6'($unsigned($random(seed)) % 24);
        rnd[11:6] = 6'($unsigned($random(seed)) % 60);
        rnd[5:0] = 6'($unsigned($random(seed)) % 60);
    endfunction : rnd

    // Reference time moves only on ticks; a commit lands on the next one
    always @(posedge sys_clk) begin
        if (srst) t_q <= 34'h000000000;
        else if (sec_tick === 1'b1) begin
            t_q <= pend_q ? stg_q : adv(t_q, setup_calendar);
            pend_q <= 1'b0;
        end
        if (flash_store_req === 1'b1) n_store++;
    end

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Waits for a tick edge; the watchdog bounds the wait
    task automatic tk();
        @(posedge sys_clk iff sec_tick === 1'b1);
    endtask : tk

    task automatic rdall();
        logic [6:0] a [4];
        // Last address drawn at random, mapped or not
        a = '{7'h78, 7'h7a, 7'h7c, 7'($random(seed))};
        foreach (a[i]) begin
            host_u.acc(1'b0, a[i], 2'b11, 16'h0000, q, ok);
            chk({ok, q}, {1'b1, img(a[i], t_q)}, "time read");
        end
    endtask : rdall

    // seconds first, year byte last; spare bits written as ones
    task automatic set_time(input logic [33:0] v, input logic [1:0] ybe);
        tk();
        host_u.acc(1'b1, 7'h78, 2'b11, {2'h3, v[11:6], 2'h3, v[5:0]}, q, ok);
        host_u.acc(1'b1, 7'h7a, 2'b11, {3'h7, v[22:18], 2'h3, v[17:12]}, q, ok);
        host_u.acc(1'b1, 7'h7c, ybe, {1'h1, v[33:27], 4'hf, v[26:23]}, q, ok);
        if (ybe[1]) {stg_q, pend_q} = {v, 1'b1};
    endtask : set_time

    initial begin
        {seed, n_fail, num_checks, n_store} = {32'd16232, 96'h0};
        {srst, main_ready, pend_q} = 3'b100;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        host_u.acc(1'b1, 7'h78, 2'b11, 16'h0505, q, ok);
        chk({ok, q}, 17'h00000, "write before ready");
        main_ready <= 1'b1;
        tk();
        rdall();
        repeat (3) tk();
        rdall();
        $display("test elapsed done");
        host_u.word(16'h8003);
        host_u.word(16'h8ac1);
        host_u.word(16'h8b00);
        host_u.word(16'h8003);
        host_u.word(16'h8204);
        host_u.word(16'h8300);
        chk(17'(n_store), 17'h00001, "flash store");
        set_time({7'h63, 4'hc, 5'h1f, 6'h17, 6'h3b, 6'h3b}, 2'b11);
        rdall();
        tk();
        rdall();
        tk();
        rdall();
        set_time(rnd(), 2'b01);
        tk();
        rdall();
        $display("test calendar done");
        repeat (4) begin
            set_time(rnd(), 2'b11);
            tk();
            rdall();
        end
        main_ready <= 1'b0;
        repeat (3) @(posedge sys_clk);
        host_u.acc(1'b0, 7'h78, 2'b11, 16'h0000, q, ok);
        chk({ok, q}, 17'h00000, "read while not ready");
        main_ready <= 1'b1;
        host_u.word(16'h8ac0);
        set_time({7'h63, 4'hc, 5'h1f, 6'h17, 6'h3b, 6'h3b}, 2'b11);
        repeat (2) tk();
        rdall();
        $display("test elapsed wrap done");
        srst <= 1'b1;
        @(posedge sys_clk);
        {srst, pend_q} <= 2'b00;
        tk();
        rdall();
        $display("test reset again done");
        final_report();
    end

    // Cuts a hang short well beyond the expected run
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        final_report();
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
endmodule : tb
